// File: core/tmcl_pkg.sv
// Shared constants, modes and carriers of the test-mode configuration loader
package tmcl_pkg;

    // Configuration word geometry
    localparam int CFG_W = 39;
    localparam int OPT_LSB = 25;
    localparam int OPT_MSB = 38;
    localparam int LIM_W = 5;
    localparam logic [LIM_W-1:0] LIM_MAX = 5'h1f;
    localparam logic [LIM_W-1:0] LIM_RST = 5'h00;
    localparam logic [CFG_W-1:0] CFG_RST = 39'h00_0000_0000;

    // Main clock and verification measurement hold time (least time, rounded up)
    localparam int MCLK_PERIOD_NS = 50;
    localparam int MEAS_HOLD_US = 1000;
    localparam int MEAS_HOLD_CYC = (MEAS_HOLD_US * 1000 + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;

    // Field decode constants
    localparam logic [4:0] BATT_BASE_DV = 5'h15;
    localparam logic [7:0] EMIT_STEP_MA = 8'h32;
    localparam logic [8:0] INTEG_MAX_US = 9'h190;
    localparam logic [8:0] INTEG_STEP_US = 9'h064;

    // Test modes selected by counting mode-step pulses
    typedef enum logic [3:0] {
        option_load_mode    = 4'h0,
        normal_cal_mode     = 4'h1,
        hyst_cal_mode       = 4'h2,
        silence_cal_mode    = 4'h3,
        chamber_cal_mode    = 4'h4,
        baseline_mode       = 4'h5,
        serial_rw_mode      = 4'h6,
        normal_verify_mode  = 4'h7,
        hyst_verify_mode    = 4'h8,
        silence_verify_mode = 4'h9,
        chamber_verify_mode = 4'ha,
        horn_check_mode     = 4'hb
    } tmcl_mode_e;

    // Nonvolatile configuration word, bit 38 first
    typedef struct packed {
        logic horn_pattern_select;
        logic end_of_service_enable;
        logic battery_silence_enable;
        logic silence_option;
        logic drift_enable;
        logic [2:0] battery_trip_field;
        logic [1:0] emitter_current_field;
        logic [1:0] integrate_period_field;
        logic [1:0] amp_gain_field;
        logic [LIM_W-1:0] normal_threshold_field;
        logic [LIM_W-1:0] hysteresis_threshold_field;
        logic [LIM_W-1:0] silence_threshold_field;
        logic [LIM_W-1:0] chamber_check_threshold_field;
        logic [LIM_W-1:0] drift_sample_field;
    } tmcl_cfg_s;

    // Decoded parametric options for the analog side
    typedef struct packed {
        logic [4:0] batt_trip_dv;
        logic [7:0] emitter_ma;
        logic [8:0] integ_us;
        logic [2:0] gain;
    } tmcl_opt_s;

    // Shift clock domain to main domain carrier
    typedef struct packed {
        logic tog;
        logic dat;
    } tmcl_link_s;

    // Translate stored codes into physical settings
    function automatic tmcl_opt_s tmcl_decode(input tmcl_cfg_s c);
        tmcl_opt_s o;
        logic [2:0] idx;
        idx = {c.battery_trip_field[0], c.battery_trip_field[1], c.battery_trip_field[2]};
        o.batt_trip_dv = BATT_BASE_DV + {2'h0, idx};
        o.emitter_ma = 8'(({6'h00, c.emitter_current_field} + 8'h01) * EMIT_STEP_MA);
        o.integ_us = INTEG_MAX_US - 9'({7'h00, c.integrate_period_field} * INTEG_STEP_US);
        o.gain = {1'b0, c.amp_gain_field} + 3'h1;
        return o;
    endfunction

endpackage

// File: core/tmcl_link.sv
// Shift clock domain front end: samples serial data and flags each shift edge
`timescale 1ns/10ps
module tmcl_link (
    input wire logic shift_clk_pin,
    input wire logic rst_n,
    input wire logic step_data_pin,
    output tmcl_pkg::tmcl_link_s link_out
);
    import tmcl_pkg::*;

    tmcl_link_s q;
    tmcl_link_s d;

    // Each rising shift edge flips the toggle and holds the data bit until the next edge
    always_comb
    begin
        d = q;
        d.tog = ~q.tog;
        d.dat = step_data_pin;
    end

    // Link state register on the programmer's shift clock
    always_ff @(posedge shift_clk_pin or negedge rst_n)
    begin
        if (!rst_n)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

    assign link_out = q;

endmodule // tmcl_link

// File: core/tmcl_loader.sv
// Test-mode sequencer and configuration word loader
`timescale 1ns/10ps
module tmcl_loader #(
    parameter int MEAS_HOLD_CYCLES = tmcl_pkg::MEAS_HOLD_CYC
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic program_enable_pin,
    input wire logic step_data_pin,
    input wire logic shift_clk_pin,
    input wire logic store_strobe_pin,
    input wire logic level_compare_out,
    input wire logic [tmcl_pkg::LIM_W-1:0] measured_level,
    output tmcl_pkg::tmcl_mode_e test_mode,
    output logic status_out_pin,
    output logic level_monitor_pin,
    output logic ramp_monitor_pin,
    output logic [tmcl_pkg::LIM_W-1:0] cal_level,
    output logic verify_valid,
    output logic horn_on,
    output logic nvm_write,
    output tmcl_pkg::tmcl_cfg_s nvm_word,
    output tmcl_pkg::tmcl_opt_s options
);
    import tmcl_pkg::*;

    localparam int SYNC_W = 6;
    localparam int CNT_W = $clog2(MEAS_HOLD_CYCLES + 1);
    localparam logic [CNT_W-1:0] HOLD_FULL = CNT_W'(MEAS_HOLD_CYCLES);
    localparam logic [CNT_W-1:0] HOLD_M1 = CNT_W'(MEAS_HOLD_CYCLES - 1);
    localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);

    typedef struct packed {
        logic [SYNC_W-1:0] s1;
        logic [SYNC_W-1:0] s2;
        logic step_p;
        logic store_p;
        logic shift_p;
        logic tog_p;
        tmcl_mode_e mode;
        logic ser_busy;
        logic step_arm;
        logic [LIM_W-1:0] level;
        logic [LIM_W-1:0] lim_norm;
        logic [LIM_W-1:0] lim_hyst;
        logic [LIM_W-1:0] lim_sil;
        logic [LIM_W-1:0] lim_cham;
        logic [LIM_W-1:0] base;
        logic [CFG_W-1:0] sr;
        tmcl_cfg_s cfg;
        logic nvm_write;
        logic [CNT_W-1:0] meas_cnt;
        logic meas_valid;
        logic meas_result;
        logic status;
        logic lvl_route;
        logic ramp_route;
        logic horn_on;
        tmcl_opt_s opt;
    } tmcl_state_s;

    logic [1:0] rst_q;
    logic rst_n;
    tmcl_link_s link;
    tmcl_state_s q;
    tmcl_state_s d;
    logic prog_s;
    logic step_s;
    logic store_s;
    logic shift_s;
    logic cmp_s;
    logic tog_s;
    logic step_rise;
    logic store_rise;
    logic store_fall;
    logic step_fall;
    logic shift_rise;
    logic link_ev;
    logic [LIM_W-1:0] verify_lim;

    // Reset release through two flops
    always_ff @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            rst_q <= 2'h0;
        end
        else
        begin
            rst_q <= {rst_q[0], 1'b1};
        end
    end
    assign rst_n = rst_q[1];

    // Shift clock domain capture of data bits
    tmcl_link u_link (
        .shift_clk_pin(shift_clk_pin),
        .rst_n(rst_n),
        .step_data_pin(step_data_pin),
        .link_out(link)
    );

    // Synchronised pin levels and their edges
    assign prog_s = q.s2[0];
    assign step_s = q.s2[1];
    assign store_s = q.s2[2];
    assign shift_s = q.s2[3];
    assign cmp_s = q.s2[4];
    assign tog_s = q.s2[5];
    assign step_rise = step_s & ~q.step_p;
    assign step_fall = ~step_s & q.step_p;
    assign store_rise = store_s & ~q.store_p;
    assign store_fall = ~store_s & q.store_p;
    assign shift_rise = shift_s & ~q.shift_p;
    assign link_ev = tog_s ^ q.tog_p;

    // Stored limit that the current verify mode checks against
    always_comb
    begin
        unique case (q.mode)
            hyst_verify_mode: verify_lim = q.cfg.hysteresis_threshold_field;
            silence_verify_mode: verify_lim = q.cfg.silence_threshold_field;
            chamber_verify_mode: verify_lim = q.cfg.chamber_check_threshold_field;
            default: verify_lim = q.cfg.normal_threshold_field;
        endcase
    end

    // Next state of the whole sequencer
    always_comb
    begin
        d = q;
        d.s1 = {link.tog, level_compare_out, shift_clk_pin, store_strobe_pin, step_data_pin,
            program_enable_pin};
        d.s2 = q.s1;
        d.step_p = step_s;
        d.store_p = store_s;
        d.shift_p = shift_s;
        d.tog_p = tog_s;
        d.nvm_write = 1'b0;
        if (!prog_s)
        begin
            d.mode = option_load_mode;
            d.ser_busy = 1'b0;
            d.step_arm = 1'b0;
            d.level = LIM_RST;
            d.meas_cnt = '0;
            d.meas_valid = 1'b0;
        end
        else
        begin
            unique case (q.mode)
                option_load_mode:
                begin
                    if (link_ev)
                    begin
                        d.sr = {link.dat, q.sr[CFG_W-1:1]};
                    end
                    if (store_fall)
                    begin
                        d.cfg[OPT_MSB:OPT_LSB] = q.sr[OPT_MSB:OPT_LSB];
                        d.nvm_write = 1'b1;
                    end
                end
                normal_cal_mode, hyst_cal_mode, silence_cal_mode, chamber_cal_mode:
                begin
                    if (link_ev && q.level != LIM_MAX)
                    begin
                        d.level = q.level + 5'h01;
                    end
                    if (store_rise)
                    begin
                        unique case (q.mode)
                            normal_cal_mode: d.lim_norm = q.level;
                            hyst_cal_mode: d.lim_hyst = q.level;
                            silence_cal_mode: d.lim_sil = q.level;
                            default: d.lim_cham = q.level;
                        endcase
                    end
                end
                baseline_mode:
                begin
                    if (link_ev && q.cfg.drift_enable)
                    begin
                        d.base = measured_level;
                    end
                    if (store_fall)
                    begin
                        d.cfg.normal_threshold_field = q.lim_norm;
                        d.cfg.hysteresis_threshold_field = q.lim_hyst;
                        d.cfg.silence_threshold_field = q.lim_sil;
                        d.cfg.chamber_check_threshold_field = q.lim_cham;
                        d.cfg.drift_sample_field = q.base;
                        d.nvm_write = 1'b1;
                    end
                end
                serial_rw_mode:
                begin
                    if (link_ev)
                    begin
                        d.sr = {link.dat, q.sr[CFG_W-1:1]};
                        d.ser_busy = 1'b1;
                    end
                    if (store_fall)
                    begin
                        d.cfg = tmcl_cfg_s'(q.sr);
                        d.nvm_write = 1'b1;
                    end
                end
                normal_verify_mode, hyst_verify_mode, silence_verify_mode, chamber_verify_mode:
                begin
                    if (shift_rise)
                    begin
                        d.meas_valid = 1'b0;
                    end
                    if (!shift_s)
                    begin
                        d.meas_cnt = '0;
                    end
                    else if (q.meas_cnt != HOLD_FULL)
                    begin
                        d.meas_cnt = q.meas_cnt + CNT_ONE;
                        if (q.meas_cnt == HOLD_M1)
                        begin
                            d.meas_valid = 1'b1;
                            d.meas_result = (measured_level > verify_lim);
                        end
                    end
                end
                horn_check_mode:
                begin
                end
                default:
                begin
                    d.mode = option_load_mode;
                end
            endcase
            // A data bit on the step pin brings a shift edge with it; a mode step has none
            if (link_ev)
            begin
                d.step_arm = 1'b0;
            end
            else if (step_rise)
            begin
                d.step_arm = 1'b1;
            end
            // A clean step pulse advances the mode at its fall; frozen once serial data started
            if (step_fall && q.step_arm && q.mode != horn_check_mode && !q.ser_busy)
            begin
                d.mode = tmcl_mode_e'(q.mode + 4'h1);
                d.level = LIM_RST;
                d.meas_cnt = '0;
                d.meas_valid = 1'b0;
                if (q.mode == baseline_mode)
                begin
                    d.sr = q.cfg;
                end
            end
        end
        // Pin routing and status output selection
        d.lvl_route = prog_s && (q.mode inside {[normal_cal_mode:baseline_mode],
            [normal_verify_mode:chamber_verify_mode]});
        d.ramp_route = d.lvl_route;
        unique case (q.mode)
            normal_cal_mode, hyst_cal_mode, silence_cal_mode, chamber_cal_mode, baseline_mode:
                d.status = cmp_s;
            serial_rw_mode: d.status = q.sr[0];
            normal_verify_mode, hyst_verify_mode, silence_verify_mode, chamber_verify_mode:
                d.status = q.meas_valid & q.meas_result;
            default: d.status = 1'b0;
        endcase
        d.horn_on = prog_s && q.mode == horn_check_mode && store_s;
        d.opt = tmcl_decode(q.cfg);
    end

    // State register
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

    // Outputs straight from the state register
    assign test_mode = q.mode;
    assign status_out_pin = q.status;
    assign level_monitor_pin = q.lvl_route;
    assign ramp_monitor_pin = q.ramp_route;
    assign cal_level = q.level;
    assign verify_valid = q.meas_valid;
    assign horn_on = q.horn_on;
    assign nvm_write = q.nvm_write;
    assign nvm_word = q.cfg;
    assign options = q.opt;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);

    a_mode_idle_low: assert property (
        !prog_s |=> q.mode == option_load_mode)
        else $error("mode left option load while enable low");

    a_mode_step_one: assert property (
        prog_s && step_fall && q.step_arm && q.mode != horn_check_mode && !q.ser_busy
        |=> q.mode == tmcl_mode_e'($past(q.mode) + 4'h1))
        else $error("mode did not advance by one");

    a_cal_level_step: assert property (
        prog_s && q.mode inside {[normal_cal_mode:chamber_cal_mode]} && link_ev && !step_fall
        && q.level != LIM_MAX |=> q.level == $past(q.level) + 5'h01)
        else $error("calibration level did not step");

    a_limit_latch: assert property (
        prog_s && q.mode == normal_cal_mode && store_rise |=> q.lim_norm == $past(q.level))
        else $error("normal limit not latched");

    a_serial_out_first: assert property (
        $rose(q.mode == serial_rw_mode) && !nvm_write |=> status_out_pin == $past(q.cfg[0]))
        else $error("serial output does not show stored bit 0");

    a_serial_commit: assert property (
        prog_s && q.mode == serial_rw_mode && store_fall
        |=> nvm_write && nvm_word == $past(q.sr))
        else $error("serial word not committed");

    a_option_partial: assert property (
        prog_s && q.mode == option_load_mode && store_fall
        |=> q.cfg[OPT_LSB-1:0] == $past(q.cfg[OPT_LSB-1:0]))
        else $error("option load touched calibration bits");

    a_no_early_store: assert property (
        q.nvm_write |-> $past(q.mode) inside {option_load_mode, baseline_mode, serial_rw_mode})
        else $error("commit outside a storing mode");

    a_verify_hold: assert property (
        $rose(q.meas_valid) |-> $past(q.meas_cnt) == HOLD_M1 && $past(shift_s))
        else $error("verify result without full hold");

    a_horn_follow: assert property (
        prog_s && q.mode == horn_check_mode && store_s && !step_rise ##1 prog_s |-> horn_on)
        else $error("horn not sounding in horn check");

endmodule // tmcl_loader

// File: dv/tmcl_prog_model.sv
// Production programmer model that drives the enable, step/data, shift and store pins
`timescale 1ns/10ps
module tmcl_prog_model #(
    parameter int STORE_NS = 10_000_000
) (
    input wire logic mclk,
    output logic program_enable_pin,
    output logic step_data_pin,
    output logic shift_clk_pin,
    output logic store_strobe_pin
);
    logic tick = 1'b0;

    // Shift timing grid of 64 ns, offset from the main clock phase
    initial
    begin
        #7;
        forever #32 tick = ~tick;
    end

    // All pins low at power-up
    initial
    begin
        program_enable_pin = 1'b0;
        step_data_pin = 1'b0;
        shift_clk_pin = 1'b0;
        store_strobe_pin = 1'b0;
    end

    // Session enable: a low level ends the session and returns to option load; the stored word is kept for the next one
    task automatic enable(input logic v);
        @(negedge mclk);
        program_enable_pin = v;
        repeat (10) @(negedge mclk);
    endtask

    // Mode-step pulses, 100 us high and 10 us low
    task automatic step(input int n);
        repeat (n)
        begin
            @(negedge mclk);
            step_data_pin = 1'b1;
            #100_000;
            @(negedge mclk);
            step_data_pin = 1'b0;
            #10_000;
        end
    endtask

    // One shift clock pulse carrying a data level, each phase at least 10 us
    task automatic shift(input logic d);
        @(negedge mclk);
        step_data_pin = d;
        @(posedge tick);
        shift_clk_pin = 1'b1;
        repeat (157) @(posedge tick);
        shift_clk_pin = 1'b0;
        repeat (157) @(posedge tick);
        @(negedge mclk);
        step_data_pin = 1'b0; // Data returns low so the next bit or step shows a fresh edge
    endtask

    // Shift pin held as a level, used as the measurement enable
    task automatic level(input logic v);
        @(posedge tick);
        shift_clk_pin = v;
    endtask

    // Store strobe level, also the horn enable
    task automatic strobe(input logic v);
        @(negedge mclk);
        store_strobe_pin = v;
    endtask

    // Store pulse, high then low; the width is shortened in simulation
    task automatic store();
        strobe(1'b1);
        #STORE_NS;
        strobe(1'b0);
        repeat (4) @(negedge mclk);
    endtask
endmodule // tmcl_prog_model

// File: dv/tmcl_loader_tb.sv
// Self-checking bench of the test-mode configuration loader
`timescale 1ns/10ps
`define CHK(nm, ex, got) \
    begin \
        total_checks++; \
        if ((got) !== (ex)) \
        begin \
            mismatches++; \
            $display("mismatch %s exp %0h got %0h", nm, ex, got); \
        end \
    end
module tmcl_loader_tb;
    import tmcl_pkg::*;
    localparam int HOLD = 20;
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic pe, sd, sc, ss;
    logic cmp_in = 1'b0;
    logic [LIM_W-1:0] meas = '0;
    tmcl_mode_e mode;
    logic st_pin, lvl_pin, rmp_pin, vvalid, horn, nvw;
    logic [LIM_W-1:0] cal;
    tmcl_cfg_s word;
    tmcl_opt_s opt;
    int mismatches = 0;
    int total_checks = 0;
    int seed = 54;
    int commits = 0;
    logic [CFG_W-1:0] exp_w = '0;
    logic [CFG_W-1:0] old_w;
    bit q[$];
    int lim[5];

    // Main clock, 50 ns
    initial
    begin
        forever #25 mclk = ~mclk;
    end

    tmcl_loader #(.MEAS_HOLD_CYCLES(HOLD)) u_dut (
        .mclk(mclk),
        .nrst(nrst),
        .program_enable_pin(pe),
        .step_data_pin(sd),
        .shift_clk_pin(sc),
        .store_strobe_pin(ss),
        .level_compare_out(cmp_in),
        .measured_level(meas),
        .test_mode(mode),
        .status_out_pin(st_pin),
        .level_monitor_pin(lvl_pin),
        .ramp_monitor_pin(rmp_pin),
        .cal_level(cal),
        .verify_valid(vvalid),
        .horn_on(horn),
        .nvm_write(nvw),
        .nvm_word(word),
        .options(opt)
    );

    tmcl_prog_model #(.STORE_NS(20_000)) u_prog (
        .mclk(mclk),
        .program_enable_pin(pe),
        .step_data_pin(sd),
        .shift_clk_pin(sc),
        .store_strobe_pin(ss)
    );

    // Count nonvolatile write pulses
    always @(posedge mclk)
    begin
        if (nvw === 1'b1)
            commits++;
    end

    // Verdict and end of run
    task automatic tally_and_finish();
        if (mismatches == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // Wait, bounded, for exactly one commit after the store pulse
    task automatic wait_commit(input int c0);
        int n;
        n = 0;
        while (commits == c0 && n < 50)
        begin
            @(negedge mclk);
            n++;
        end
        repeat (2) @(negedge mclk);
        `CHK("commit", c0 + 1, commits)
    endtask

    // Decoded options worked out from the stored codes
    task automatic chk_opt();
        int t;
        t = exp_w[33:31];
        `CHK("trip", 21 + 4 * (t % 2) + 2 * ((t / 2) % 2) + t / 4, opt.batt_trip_dv)
        `CHK("emitter", 50 * (exp_w[30:29] + 1), opt.emitter_ma)
        `CHK("integ", 400 - 100 * exp_w[28:27], opt.integ_us)
        `CHK("gain", exp_w[26:25] + 1, opt.gain)
    endtask

    // Main sequence
    initial
    begin
        int c0;
        int n;
        repeat (5) @(negedge mclk);
        nrst = 1'b1;
        repeat (5) @(negedge mclk);
        `CHK("mode_rst", 0, mode)
        `CHK("word_rst", 0, word)
        // Option load: two surplus bits, then 14 options with drift enabled
        u_prog.enable(1'b1);
        for (int i = 0; i < 16; i++)
            q.push_back(i == 11 ? 1'b1 : 1'($random(seed)));
        foreach (q[i])
            u_prog.shift(q[i]);
        for (int i = 2; i < 16; i++)
            exp_w[23 + i] = q[i];
        c0 = commits;
        u_prog.store();
        wait_commit(c0);
        `CHK("opt_word", exp_w, word)
        `CHK("opt_mode", 0, mode)
        chk_opt();
        // Calibration of the four limits; latching must not commit
        c0 = commits;
        for (int m = 1; m < 5; m++)
        begin
            cmp_in = 1'($random(seed));
            u_prog.step(1);
            lim[m] = 1 + ($unsigned($random(seed)) % 3);
            repeat (lim[m]) u_prog.shift(1'b0);
            `CHK("cal_mode", m, mode)
            `CHK("cal_level", lim[m], cal)
            `CHK("ramp_route", 1, rmp_pin)
            `CHK("level_route", 1, lvl_pin)
            `CHK("cmp_route", cmp_in, st_pin)
            u_prog.store();
        end
        `CHK("no_early_commit", c0, commits)
        // Baseline sample, then one commit of limits and sample
        meas = 5'($random(seed));
        u_prog.step(1);
        `CHK("base_mode", 5, mode)
        u_prog.shift(1'b0);
        exp_w[24:0] = {5'(lim[1]), 5'(lim[2]), 5'(lim[3]), 5'(lim[4]), meas};
        u_prog.store();
        wait_commit(c0);
        `CHK("cal_word", exp_w, word)
        // Serial mode: read back the stored word while writing a new one
        old_w = exp_w;
        u_prog.step(1);
        `CHK("ser_mode", 6, mode)
        `CHK("ser_out0", old_w[0], st_pin)
        q.delete();
        for (int i = 0; i < CFG_W; i++)
            q.push_back(1'($random(seed)));
        for (int i = 0; i < CFG_W; i++)
        begin
            u_prog.shift(q[i]);
            exp_w[i] = q[i];
            if (i < CFG_W - 1)
                `CHK("ser_out", old_w[i + 1], st_pin)
        end
        `CHK("ser_freeze", 6, mode)
        c0 = commits;
        u_prog.store();
        wait_commit(c0);
        `CHK("ser_word", exp_w, word)
        chk_opt();
        // Enable low returns to option load and ignores steps
        u_prog.enable(1'b0);
        `CHK("pe_low_mode", 0, mode)
        u_prog.step(1);
        `CHK("pe_low_step", 0, mode)
        // Verification against each stored limit in turn; hold scaled with the counter
        u_prog.enable(1'b1);
        u_prog.step(6);
        for (int v = 0; v < 4; v++)
        begin
            u_prog.step(1);
            `CHK("ver_mode", 7 + v, mode)
            meas = 5'($random(seed));
            u_prog.level(1'b1);
            n = 0;
            while (vvalid !== 1'b1 && n < 200)
            begin
                @(negedge mclk);
                n++;
            end
            @(negedge mclk);
            `CHK("ver_wait", 1, n >= HOLD && n <= HOLD + 4)
            `CHK("ver_valid", 1, vvalid)
            `CHK("ver_status", meas > exp_w[24 - 5 * v -: 5], st_pin)
            u_prog.level(1'b0);
        end
        // Horn check and mode saturation
        u_prog.step(1);
        `CHK("horn_mode", 11, mode)
        u_prog.step(1);
        `CHK("mode_sat", 11, mode)
        c0 = commits;
        u_prog.strobe(1'b1);
        repeat (6) @(negedge mclk);
        `CHK("horn_on", 1, horn)
        u_prog.strobe(1'b0);
        repeat (6) @(negedge mclk);
        `CHK("horn_off", 0, horn)
        `CHK("horn_no_commit", c0, commits)
        tally_and_finish();
    end

    // Watchdog, well past the expected run length
    initial
    begin
        #4_600_000;
        mismatches++;
        tally_and_finish();
    end
endmodule // tmcl_loader_tb
